//--- common/eclwf_pkg.sv
// ---------------------------------------------------------------
// lead word formation constants
// ---------------------------------------------------------------
package eclwf_pkg;
    localparam int SAMPLE_W   = 24;               // signed sample width per channel
    localparam int WORD_W     = 24;               // output word width
    localparam int NUM_WORDS  = 5;                // words per frame
    localparam int FIFO_DEPTH = 4;                // output buffer depth
    // field positions of the three selector bits in their host registers
    localparam int FMT_BIT_POS   = 4;             // frame_control bit
    localparam int DIFF_BIT_POS  = 10;            // channel_control bit
    localparam int CE_BIT_POS    = 8;             // common_mode_control bit
    // mode codes {format, differential, common electrode}
    localparam logic [2:0] MODE_DIG_LEAD = 3'h0;
    localparam logic [2:0] MODE_CE_A     = 3'h1;
    localparam logic [2:0] MODE_ANA_LEAD = 3'h2;
    localparam logic [2:0] MODE_ELEC     = 3'h4;
    localparam logic [2:0] MODE_CE_B     = 3'h5;
    // data rate codes; digital lead math is offered at RATE_2K and RATE_16K only
    localparam logic [1:0] RATE_2K   = 2'h0;
    localparam logic [1:0] RATE_16K  = 2'h1;
    localparam logic [1:0] RATE_128K = 2'h2;
    localparam int DIV3 = 3;                      // averaging divisor
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01,
        ST_EMIT = 2'b10
    } eclwf_state_type;
endpackage

//--- core/eclwf_fifo.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// small synchronous fifo, valid/ready both sides
// ---------------------------------------------------------------
module eclwf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage
    logic [AW-1:0]    wr_q;            // write pointer
    logic [AW-1:0]    rd_q;            // read pointer
    logic [AW:0]      cnt_q;           // fill level
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // full only at DEPTH words; the level is one bit wider than the pointers
    // so that DEPTH itself does not wrap to zero
    assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // eclwf_fifo

//--- core/eclwf_core.sv
`timescale 1ns/1ps
module eclwf_core (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    // selector bits
    input  wire logic                                output_format_select,
    input  wire logic                                input_differential_select,
    input  wire logic                                common_electrode_enable,
    input  wire logic [1:0]                          data_rate_select,
    input  wire logic [5:0]                          common_mode_select,
    // sample input: ch0 LA, ch1 LL, ch2 RA/V3, ch3 V1, ch4 V2
    input  wire logic                                smp_valid,
    output logic                                     smp_ready,
    input  wire logic signed [eclwf_pkg::SAMPLE_W-1:0] smp_ch0,
    input  wire logic signed [eclwf_pkg::SAMPLE_W-1:0] smp_ch1,
    input  wire logic signed [eclwf_pkg::SAMPLE_W-1:0] smp_ch2,
    input  wire logic signed [eclwf_pkg::SAMPLE_W-1:0] smp_ch3,
    input  wire logic signed [eclwf_pkg::SAMPLE_W-1:0] smp_ch4,
    // word output stream
    output logic                                     word_valid,
    input  wire logic                                word_ready,
    output logic [eclwf_pkg::WORD_W-1:0]             word_data,
    output logic [2:0]                               word_index,
    output logic                                     mode_error
);
    localparam int W = eclwf_pkg::SAMPLE_W;
    localparam int XW = W + 4;                        // headroom for sums
    typedef logic signed [XW-1:0] eclwf_wide_type;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    eclwf_pkg::eclwf_state_type st_q;
    eclwf_wide_type             wd_q [eclwf_pkg::NUM_WORDS]; // computed words
    logic [2:0]                 idx_q;                      // next word to emit
    logic                       out_take;                   // output flop may load
    logic                       err_q;                      // unsupported setting
    logic                       fifo_ready;
    logic                       fifo_valid;
    logic [eclwf_pkg::WORD_W+2:0] fifo_out;
    eclwf_wide_type             la, ll, ra, v1, v2, ct;
    eclwf_wide_type             calc [eclwf_pkg::NUM_WORDS];
    logic [2:0]                 mode_now;
    logic                       mode_bad;

    assign la = XW'(smp_ch0);
    assign ll = XW'(smp_ch1);
    assign ra = XW'(smp_ch2);
    assign v1 = XW'(smp_ch3);
    assign v2 = XW'(smp_ch4);
    // the common_mode_select bits shape the analog common level only and
    // are never read here, so digital lead words cannot depend on them
    assign mode_now = {output_format_select, input_differential_select,
                       common_electrode_enable};
    // central terminal average, truncating division
    assign ct = (la + ll + ra) / XW'(eclwf_pkg::DIV3);

    // unsupported mode/rate combination; words are then zero
    always_comb begin
        mode_bad = 1'b0;
        case (mode_now)
            eclwf_pkg::MODE_DIG_LEAD:
                mode_bad = !(data_rate_select == eclwf_pkg::RATE_2K ||
                             data_rate_select == eclwf_pkg::RATE_16K);
            eclwf_pkg::MODE_CE_A,
            eclwf_pkg::MODE_ANA_LEAD,
            eclwf_pkg::MODE_ELEC,
            eclwf_pkg::MODE_CE_B:     mode_bad = 1'b0;
            default:                  mode_bad = 1'b1;
        endcase
    end

    // ---------------------------------------------------------------
    // word formation per mode
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < eclwf_pkg::NUM_WORDS; i++) begin
            calc[i] = '0;
        end
        case (mode_now)
            eclwf_pkg::MODE_DIG_LEAD: begin
                calc[0] = la - ra;
                calc[1] = ll - ra;
                calc[2] = ll - la;
                calc[3] = v1 - ct;
                calc[4] = v2 - ct;
            end
            eclwf_pkg::MODE_ANA_LEAD: begin
                // channels already hold leads; lead II arrives inverted
                calc[0] = la;
                calc[1] = -ll;
                calc[2] = ra;
                calc[3] = v1;
                calc[4] = v2;
            end
            eclwf_pkg::MODE_CE_A: begin
                // ch0 = LA-RA, ch1 = LL-RA, ch2 = V3-RA (ra referenced)
                calc[0] = la;
                calc[1] = ll;
                calc[2] = ra - (la + ll) / XW'(eclwf_pkg::DIV3);
                calc[3] = v1 - (la + ll) / XW'(eclwf_pkg::DIV3);
                calc[4] = v2 - (la + ll) / XW'(eclwf_pkg::DIV3);
            end
            eclwf_pkg::MODE_ELEC: begin
                calc[0] = la;
                calc[1] = ll;
                calc[2] = ra;
                calc[3] = v1;
                calc[4] = v2;
            end
            eclwf_pkg::MODE_CE_B: begin
                // ch2 carries V3 here; order LA, LL, V1, V2, V3
                calc[0] = la;
                calc[1] = ll;
                calc[2] = v1;
                calc[3] = v2;
                calc[4] = ra;
            end
            default: begin
                calc[0] = '0;
            end
        endcase
        if (mode_bad) begin
            for (int i = 0; i < eclwf_pkg::NUM_WORDS; i++) begin
                calc[i] = '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // sequencing: take a sample, emit five words in order
    // ---------------------------------------------------------------
    // control state machine; smp_ready is a flop that mirrors the idle state except in the first cycle after reset,
    // when it is still low, so the port never carries a combinational path
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q      <= eclwf_pkg::ST_IDLE;
            idx_q     <= 3'h0;
            smp_ready <= 1'b0;
        end else begin
            case (st_q)
                eclwf_pkg::ST_IDLE: begin
                    if (smp_valid && smp_ready) begin
                        st_q      <= eclwf_pkg::ST_EMIT;
                        idx_q     <= 3'h0;
                        smp_ready <= 1'b0;
                    end else begin
                        smp_ready <= 1'b1;
                    end
                end
                eclwf_pkg::ST_EMIT: begin
                    // stalls while the buffer is full
                    if (fifo_ready) begin
                        if (idx_q == 3'(eclwf_pkg::NUM_WORDS - 1)) begin
                            st_q      <= eclwf_pkg::ST_IDLE;
                            smp_ready <= 1'b1;
                        end
                        idx_q <= idx_q + 3'h1;
                    end
                end
                default: begin
                    st_q      <= eclwf_pkg::ST_IDLE;
                    smp_ready <= 1'b0;
                end
            endcase
        end
    end

    // word capture per sample
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < eclwf_pkg::NUM_WORDS; i++) begin
                wd_q[i] <= '0;
            end
            err_q  <= 1'b0;
        end else if (smp_valid && smp_ready) begin
            wd_q   <= calc;
            err_q  <= mode_bad;
        end
    end

    // ---------------------------------------------------------------
    // output buffer, carries word plus index
    // ---------------------------------------------------------------
    eclwf_fifo #(
        .WIDTH (eclwf_pkg::WORD_W + 3),
        .DEPTH (eclwf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (st_q == eclwf_pkg::ST_EMIT),
        .in_ready  (fifo_ready),
        .in_data   ({idx_q, wd_q[idx_q][eclwf_pkg::WORD_W-1:0]}),
        .out_valid (fifo_valid),
        .out_ready (out_take),
        .out_data  (fifo_out)
    );

    // buffer pops exactly when the output flop loads, so no word is lost
    assign out_take = !word_valid || word_ready;

    // outputs from flops: register after the buffer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_valid <= 1'b0;
            word_data  <= '0;
            word_index <= 3'h0;
            mode_error <= 1'b0;
        end else begin
            mode_error <= err_q;
            if (out_take) begin
                word_valid <= fifo_valid;
                word_data  <= fifo_out[eclwf_pkg::WORD_W-1:0];
                word_index <= fifo_out[eclwf_pkg::WORD_W+2:eclwf_pkg::WORD_W];
            end
        end
    end
endmodule // eclwf_core

//--- verification/eclwf_core_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the word former
// ----------------------------------------
module eclwf_core_sva (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        sys_rst,
    // selector bits
    input wire logic                        output_format_select,
    input wire logic                        input_differential_select,
    input wire logic                        common_electrode_enable,
    input wire logic [1:0]                  data_rate_select,
    // sample and word streams
    input wire logic                        smp_valid,
    input wire logic                        smp_ready,
    input wire logic                        word_valid,
    input wire logic                        word_ready,
    input wire logic [eclwf_pkg::WORD_W-1:0] word_data,
    input wire logic [2:0]                  word_index,
    input wire logic                        mode_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] mode_w;      // selector code as one field
    logic [2:0] exp_idx_q;   // index the next word must carry
    logic       take_w;      // sample accepted this edge
    assign mode_w = {output_format_select, input_differential_select, common_electrode_enable};
    assign take_w = smp_valid && smp_ready;
    // expected index tracks handshakes, wraps after the fifth word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) exp_idx_q <= 3'h0;
        else if (word_valid && word_ready)
            exp_idx_q <= (word_index == 3'h4) ? 3'h0 : word_index + 3'h1;
    end
    property p_hold;
        word_valid && !word_ready |=> word_valid && $stable(word_data) && $stable(word_index);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    property p_range;
        word_valid |-> word_index <= 3'h4;
    endproperty
    a_range: assert property (p_range) else $error("word index beyond five");
    property p_order;
        word_valid |-> word_index == exp_idx_q;
    endproperty
    a_order: assert property (p_order) else $error("word index out of order");
    property p_answer;
        take_w |-> ##[1:6] word_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no word after sample");
    property p_refuse;
        take_w |=> !smp_ready [*5];
    endproperty
    a_refuse: assert property (p_refuse) else $error("sample taken during emit");
    property p_bad;
        take_w && (mode_w inside {3'h3, 3'h6, 3'h7}) |-> ##[1:6] mode_error;
    endproperty
    a_bad: assert property (p_bad) else $error("undefined mode not flagged");
    property p_rate;
        take_w && mode_w == eclwf_pkg::MODE_DIG_LEAD && data_rate_select[1]
            |-> ##[1:6] mode_error;
    endproperty
    a_rate: assert property (p_rate) else $error("lead math at fast rate");
    property p_good;
        take_w && !(mode_w inside {3'h3, 3'h6, 3'h7})
            && !(mode_w == eclwf_pkg::MODE_DIG_LEAD && data_rate_select[1])
            |-> ##[1:6] !mode_error;
    endproperty
    a_good: assert property (p_good) else $error("valid mode flagged");
endmodule // eclwf_core_sva

bind eclwf_core eclwf_core_sva u_sva (.clk(clk), .sys_rst(sys_rst),
    .output_format_select(output_format_select),
    .input_differential_select(input_differential_select),
    .common_electrode_enable(common_electrode_enable), .data_rate_select(data_rate_select),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_index(word_index),
    .mode_error(mode_error));

//--- verification/eclwf_host_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// host reading words, slow start then random stalls
// ----------------------------------------
module eclwf_host_sink (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // word stream
    input  wire logic word_valid,
    output logic      word_ready
);
    int     slow_q = 0;         // cycles since reset, long stall fills the buffer
    integer seed   = 32'h35B5;  // stall pattern seed
    integer r;                  // random draw
    // ready is free to move; host never holds a word itself
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slow_q     <= 0;
            word_ready <= 1'b0;
        end else begin
            r = $random(seed);
            if (slow_q < 60) slow_q <= slow_q + 1;
            word_ready <= (slow_q >= 60) && r[0];
        end
    end
endmodule // eclwf_host_sink

//--- verification/eclwf_core_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module eclwf_core_tb;
    // ----------------------------------------
    // stimulus, design and host
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        output_format_select = 1'b0;
    logic        input_differential_select = 1'b0;
    logic        common_electrode_enable = 1'b0;
    logic [1:0]  data_rate_select = 2'h0;
    logic [5:0]  common_mode_select = 6'h00;
    logic        smp_valid = 1'b0;
    logic signed [eclwf_pkg::SAMPLE_W-1:0] ch [5] = '{default: 24'h000000};
    logic        smp_ready, word_valid, word_ready, mode_error;
    logic [eclwf_pkg::WORD_W-1:0] word_data;
    logic [2:0]  word_index;
    int          failures = 0;
    int          checks = 0;
    integer      seed = 32'h35B5;
    logic [26:0] exp_q [$];     // {index, word} from the model
    always #5 clk = ~clk;
    eclwf_core dut (.clk(clk), .sys_rst(sys_rst), .output_format_select(output_format_select),
        .input_differential_select(input_differential_select),
        .common_electrode_enable(common_electrode_enable), .data_rate_select(data_rate_select),
        .common_mode_select(common_mode_select), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .smp_ch0(ch[0]), .smp_ch1(ch[1]), .smp_ch2(ch[2]), .smp_ch3(ch[3]), .smp_ch4(ch[4]),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .word_index(word_index), .mode_error(mode_error));
    eclwf_host_sink host (.clk(clk), .sys_rst(sys_rst), .word_valid(word_valid),
        .word_ready(word_ready));
    // ----------------------------------------
    // scoreboard, one compare per accepted word
    // ----------------------------------------
    always @(posedge clk) begin
        if (!sys_rst && word_valid === 1'b1 && word_ready === 1'b1) begin
            if (exp_q.size() == 0) `CHK("extra word", 1'b0, 1'b1)
            else begin
                `CHK("word", exp_q[0], {word_index, word_data})
                void'(exp_q.pop_front());
            end
        end
    end
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // model the five words, then offer the sample until taken
    task automatic send(input logic [2:0] m, input logic [1:0] r);
        int c [5];
        int w [5];
        int t;
        bit ok;
        for (int i = 0; i < 5; i++) c[i] = $random(seed) >>> 11;
        t = (m == 3'h1) ? (c[0] + c[1]) / 3 : (c[0] + c[1] + c[2]) / 3;
        case (m)
            3'h0: w = '{c[0]-c[2], c[1]-c[2], c[1]-c[0], c[3]-t, c[4]-t};
            3'h1: w = '{c[0], c[1], c[2]-t, c[3]-t, c[4]-t};
            3'h2: w = '{c[0], -c[1], c[2], c[3], c[4]};
            3'h4: w = '{c[0], c[1], c[2], c[3], c[4]};
            3'h5: w = '{c[0], c[1], c[3], c[4], c[2]};
            default: w = '{0, 0, 0, 0, 0};
        endcase
        if (m == 3'h0 && r[1]) w = '{0, 0, 0, 0, 0};
        for (int i = 0; i < 5; i++) exp_q.push_back({3'(i), 24'(w[i])});
        @(posedge clk);
        smp_valid <= 1'b1;
        for (int i = 0; i < 5; i++) ch[i] <= 24'(c[i]);
        common_mode_select <= 6'($random(seed));
        ok = 0;
        for (int k = 0; k < 300 && !ok; k++) begin
            @(negedge clk);
            ok = smp_ready;
            @(posedge clk);
        end
        smp_valid <= 1'b0;
        if (!ok) begin
            failures++;
            test_done();
        end
    endtask
    // ----------------------------------------
    // every selector code four times over, three samples back to back each pass
    // ----------------------------------------
    initial begin
        logic [2:0] m;
        logic [1:0] r;
        logic       bad;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int g = 0; g < 32; g++) begin
            m = 3'(g);
            r = (m == 3'h0) ? 2'(g / 8) : 2'($random(seed) & 1);
            @(posedge clk);
            {output_format_select, input_differential_select, common_electrode_enable} <= m;
            data_rate_select <= r;
            for (int s = 0; s < 3; s++) send(m, r);
            for (int k = 0; k < 500 && exp_q.size() != 0; k++) @(posedge clk);
            if (exp_q.size() != 0) begin
                failures++;
                test_done();
            end
            @(posedge clk);
            bad = (m inside {3'h3, 3'h6, 3'h7}) || (m == 3'h0 && r[1]);
            `CHK("mode_error", bad, mode_error)
        end
        test_done();
    end
endmodule // eclwf_core_tb
